/* power_cycling_defs.svh */
`ifndef POWER_CYCLING_DEFS_SVH
`define POWER_CYCLING_DEFS_SVH

// register locations on the system monitoring address
`define PWR_MODE_OFFSET 8'h00
`define REASON_INFO_OFFSET 8'h28
`define REG_ADDR_W 8

// powering mode values
`define PWR_MODE_CABLE 8'h01
`define PWR_MODE_BATTERY 8'h02

// information word field positions
`define SHUTDOWN_LSB 0
`define WAKE_LSB 4
`define RESTART_LSB 8
`define INFO_CLEAR_VALUE 16'h0000

// shutdown reason codes
`define SD_BUTTON 4'h1
`define SD_LOW_BATTERY 4'h2
`define SD_TIMED 4'h3
`define SD_SIMPLE_SCHED 4'h4
`define SD_EXT_SCHED 4'h5
`define SD_EVENT 4'h6

// wake reason codes
`define WK_BUTTON 4'h1
`define WK_MAIN_CABLE 4'h2
`define WK_HOST_RESET 4'h3
`define WK_EXT_INPUT 4'h4
`define WK_SIMPLE_SCHED 4'h5
`define WK_EXT_SCHED 4'h6
`define WK_EVENT 4'h7

// timing: rate and documented times
`define CLK_HZ 100000000
`define RUN_TIME_SEC_DEFAULT 70
`define SLEEP_POLL_SEC 10
`define SLEEP_POLL_CYCLES (`SLEEP_POLL_SEC * `CLK_HZ)
`define SHUTDOWN_TIME_SEC_DEFAULT 5
`define BEEP_CYCLES_DEFAULT 10000000
`define BLINK_CABLE_CYCLES_DEFAULT 40000000
`define BLINK_BATTERY_CYCLES_DEFAULT 120000000
`define BLINK_ON_CYCLES_DEFAULT 40000000

`endif

/* power_cycling_pkg.sv */
package power_cycling_pkg;

    typedef enum {
        ST_CABLE_RUN,
        ST_BATTERY_RUN,
        ST_SHUTDOWN,
        ST_SLEEP
    } pwr_state_t;

endpackage

/* tick_counter.sv */
`timescale 1ns/10ps

module tick_counter (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // control
    input wire logic clear,
    input wire logic [31:0] period,
    // result
    output logic tick
);

    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } tick_state_t;

    tick_state_t st_r;
    tick_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clear) begin
            st_nxt.count = 32'h0;
        end else if (st_r.count >= period - 32'h1) begin
            st_nxt.count = 32'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.count = st_r.count + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule // tick_counter

/* blink_beep.sv */
`timescale 1ns/10ps

module blink_beep (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // control
    input wire logic running,
    input wire logic slowBlink,
    input wire logic solid,
    input wire logic beepStart,
    input wire logic [31:0] cableCycles,
    input wire logic [31:0] batteryCycles,
    input wire logic [31:0] onCycles,
    input wire logic [31:0] beepCycles,
    // outputs
    output logic statusLed,
    output logic beeper
);

    typedef struct packed {
        logic [31:0] phase;
        logic [31:0] beepCnt;
        logic led;
        logic beep;
    } bb_state_t;

    bb_state_t st_r;
    bb_state_t st_nxt;
    logic [31:0] periodSel;

    always_comb begin
        periodSel = slowBlink ? batteryCycles : cableCycles;
        st_nxt = st_r;
        if (!running) begin
            st_nxt.phase = 32'h0;
            st_nxt.led = solid;
        end else begin
            st_nxt.phase = (st_r.phase >= periodSel - 32'h1) ? 32'h0 : st_r.phase + 32'h1;
            st_nxt.led = (st_r.phase < onCycles);
        end
        if (beepStart) begin
            st_nxt.beepCnt = beepCycles;
        end else if (st_r.beepCnt != 32'h0) begin
            st_nxt.beepCnt = st_r.beepCnt - 32'h1;
        end
        st_nxt.beep = (st_nxt.beepCnt != 32'h0);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign statusLed = st_r.led;
    assign beeper = st_r.beep;

endmodule // blink_beep

/* power_cycling_sequencer.sv */
//
// Notes on behaviour
// - powering mode kept in a register, readable any time at location 0x00.
// - powering mode reads 0x01 on cable power, 0x02 on battery.
// - cable failure switches to battery, beeps, slows blink, mode shows battery.
// - battery run time without cable (70 s default) starts safe shutdown, then sleep.
// - button press while running starts safe shutdown at once, then sleep.
// - the real-time clock keeps running during sleep.
// - sleep ends on button, cable applied or changed, or scheduler event.
// - sleep samples cable power every 10 s and restarts the system if cable power was applied or changed.
// - button during sleep wakes at once and runs on battery if no cable power is present, else on cable.
// - external input loss switches to battery likewise; absence leads to shutdown.
// - sleep cuts system power even while cable power is present.
// - external input applied or changed also wakes from sleep.
// - 16-bit information word at location 0x28 with separate reason fields.
// - bits 3:0 hold shutdown reason codes 0x1 to 0x6.
// - bits 7:4 hold wake reason codes 0x1 to 0x7.
// - bits 11:8 hold controller restart reason.
// - host writing 0x0000 to the information word clears all reasons.
//
`timescale 1ns/10ps
`include "power_cycling_defs.svh"

module power_cycling_sequencer #(
    parameter logic [31:0] RUN_TIME_SEC = `RUN_TIME_SEC_DEFAULT,
    parameter logic [31:0] SHUTDOWN_SEC = `SHUTDOWN_TIME_SEC_DEFAULT,
    parameter logic [31:0] SEC_CYCLES = `CLK_HZ,
    parameter logic [31:0] POLL_CYCLES = `SLEEP_POLL_CYCLES,
    parameter logic [31:0] BEEP_CYCLES = `BEEP_CYCLES_DEFAULT,
    parameter logic [31:0] BLINK_CABLE_CYCLES = `BLINK_CABLE_CYCLES_DEFAULT,
    parameter logic [31:0] BLINK_BATTERY_CYCLES = `BLINK_BATTERY_CYCLES_DEFAULT,
    parameter logic [31:0] BLINK_ON_CYCLES = `BLINK_ON_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // power sources
    input wire logic mainCablePresent,
    input wire logic extInputPresent,
    input wire logic extInputFitted,
    // wake and shutdown events
    input wire logic buttonPress,
    input wire logic lowBattery,
    input wire logic simpleSchedWake,
    input wire logic extSchedWake,
    input wire logic eventWake,
    input wire logic simpleSchedOff,
    input wire logic extSchedOff,
    input wire logic eventOff,
    input wire logic hostRebooted,
    input wire logic [3:0] restartCause,
    input wire logic restartCauseValid,
    // register access
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regRvalid,
    // system control
    output logic systemPowerOn,
    output logic onBattery,
    output logic shutdownRequest,
    output logic sleepActive,
    output logic rtcRun,
    output logic statusLed,
    output logic beeper
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        power_cycling_pkg::pwr_state_t state;
        logic [7:0] pwrMode;
        logic [15:0] info;
        logic [31:0] secCnt;
        logic [31:0] secElapsed;
        logic mainPrev;
        logic extPrev;
        logic [15:0] rdata;
        logic rvalid;
        logic powerOn;
        logic shutReq;
        logic beepStart;
        logic onBat;
        logic asleep;
        logic rtcOn;
    } seq_state_t;

    seq_state_t st_r;
    seq_state_t st_nxt;
    logic pollTick;
    logic pollClear;
    logic cableNow;
    logic cableChanged;
    logic running;
    logic secWrap;

    ////////////////////////////////////////////////////////////////////////////
    // sleep poll timer and indicator

    assign pollClear = (st_r.state != power_cycling_pkg::ST_SLEEP);

    tick_counter u_poll (
        .core_clk(core_clk),
        .resetn(resetn),
        .clear(pollClear),
        .period(POLL_CYCLES),
        .tick(pollTick)
    );

    assign running = (st_r.state == power_cycling_pkg::ST_CABLE_RUN) ||
                     (st_r.state == power_cycling_pkg::ST_BATTERY_RUN);

    blink_beep u_ind (
        .core_clk(core_clk),
        .resetn(resetn),
        .running(running),
        .slowBlink(st_r.state == power_cycling_pkg::ST_BATTERY_RUN),
        .solid(st_r.state == power_cycling_pkg::ST_SHUTDOWN),
        .beepStart(st_r.beepStart),
        .cableCycles(BLINK_CABLE_CYCLES),
        .batteryCycles(BLINK_BATTERY_CYCLES),
        .onCycles(BLINK_ON_CYCLES),
        .beepCycles(BEEP_CYCLES),
        .statusLed(statusLed),
        .beeper(beeper)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign cableNow = mainCablePresent || (extInputFitted && extInputPresent);
    assign cableChanged = (mainCablePresent != st_r.mainPrev) ||
                          (extInputFitted && (extInputPresent != st_r.extPrev));
    assign secWrap = (st_r.secCnt >= SEC_CYCLES - 32'h1);

    always_comb begin
        st_nxt = st_r;
        st_nxt.beepStart = 1'b0;
        st_nxt.rvalid = 1'b0;
        st_nxt.secCnt = secWrap ? 32'h0 : st_r.secCnt + 32'h1;
        if (secWrap) begin
            st_nxt.secElapsed = st_r.secElapsed + 32'h1;
        end
        case (st_r.state)
            power_cycling_pkg::ST_CABLE_RUN: begin
                st_nxt.mainPrev = mainCablePresent;
                st_nxt.extPrev = extInputPresent;
                if (buttonPress || simpleSchedOff || extSchedOff || eventOff) begin
                    st_nxt.state = power_cycling_pkg::ST_SHUTDOWN;
                    st_nxt.secElapsed = 32'h0;
                end else if (!cableNow) begin
                    st_nxt.state = power_cycling_pkg::ST_BATTERY_RUN;
                    st_nxt.pwrMode = `PWR_MODE_BATTERY;
                    st_nxt.beepStart = 1'b1;
                    st_nxt.secElapsed = 32'h0;
                    st_nxt.secCnt = 32'h0;
                end
            end
            power_cycling_pkg::ST_BATTERY_RUN: begin
                st_nxt.mainPrev = mainCablePresent;
                st_nxt.extPrev = extInputPresent;
                if (buttonPress || lowBattery || simpleSchedOff || extSchedOff || eventOff ||
                    (!cableNow && st_r.secElapsed >= RUN_TIME_SEC)) begin
                    st_nxt.state = power_cycling_pkg::ST_SHUTDOWN;
                    st_nxt.secElapsed = 32'h0;
                end else if (cableNow) begin
                    st_nxt.state = power_cycling_pkg::ST_CABLE_RUN;
                    st_nxt.pwrMode = `PWR_MODE_CABLE;
                end
            end
            power_cycling_pkg::ST_SHUTDOWN: begin
                if (st_r.secElapsed >= SHUTDOWN_SEC) begin
                    st_nxt.state = power_cycling_pkg::ST_SLEEP;
                    st_nxt.powerOn = 1'b0;
                    st_nxt.mainPrev = mainCablePresent;
                    st_nxt.extPrev = extInputPresent;
                end
            end
            power_cycling_pkg::ST_SLEEP: begin
                if (buttonPress || simpleSchedWake || extSchedWake || eventWake ||
                    (pollTick && cableChanged && cableNow)) begin
                    st_nxt.powerOn = 1'b1;
                    if (pollTick && cableChanged && cableNow && !buttonPress) begin
                        st_nxt.state = power_cycling_pkg::ST_CABLE_RUN;
                        st_nxt.pwrMode = `PWR_MODE_CABLE;
                    end else begin
                        st_nxt.state = cableNow ? power_cycling_pkg::ST_CABLE_RUN
                                                : power_cycling_pkg::ST_BATTERY_RUN;
                        st_nxt.pwrMode = cableNow ? `PWR_MODE_CABLE : `PWR_MODE_BATTERY;
                    end
                    st_nxt.secElapsed = 32'h0;
                    st_nxt.secCnt = 32'h0;
                end else if (pollTick) begin
                    st_nxt.mainPrev = mainCablePresent;
                    st_nxt.extPrev = extInputPresent;
                end
            end
            default: begin
                st_nxt.state = power_cycling_pkg::ST_CABLE_RUN;
            end
        endcase
        st_nxt.shutReq = (st_nxt.state == power_cycling_pkg::ST_SHUTDOWN);
        st_nxt.onBat = (st_nxt.pwrMode == `PWR_MODE_BATTERY);
        st_nxt.asleep = !st_nxt.powerOn;
        st_nxt.rtcOn = 1'b1;

        // information word: host clear first, hardware latch wins over it
        if (regWrite && regAddr == `REASON_INFO_OFFSET && regWdata == `INFO_CLEAR_VALUE) begin
            st_nxt.info = `INFO_CLEAR_VALUE;
        end
        if (st_r.state != power_cycling_pkg::ST_SHUTDOWN &&
            st_nxt.state == power_cycling_pkg::ST_SHUTDOWN) begin
            st_nxt.info[`SHUTDOWN_LSB +: 4] = buttonPress ? `SD_BUTTON :
                lowBattery ? `SD_LOW_BATTERY :
                simpleSchedOff ? `SD_SIMPLE_SCHED :
                extSchedOff ? `SD_EXT_SCHED :
                eventOff ? `SD_EVENT : `SD_TIMED;
        end
        if (st_r.state == power_cycling_pkg::ST_SLEEP &&
            st_nxt.state != power_cycling_pkg::ST_SLEEP) begin
            st_nxt.info[`WAKE_LSB +: 4] = buttonPress ? `WK_BUTTON :
                simpleSchedWake ? `WK_SIMPLE_SCHED :
                extSchedWake ? `WK_EXT_SCHED :
                eventWake ? `WK_EVENT :
                (mainCablePresent != st_r.mainPrev) ? `WK_MAIN_CABLE
                                                    : `WK_EXT_INPUT;
        end else if (hostRebooted && running) begin
            st_nxt.info[`WAKE_LSB +: 4] = `WK_HOST_RESET;
        end
        if (restartCauseValid) begin
            st_nxt.info[`RESTART_LSB +: 4] = restartCause;
        end

        // register reads
        if (regRead) begin
            st_nxt.rvalid = 1'b1;
            case (regAddr)
                `PWR_MODE_OFFSET: st_nxt.rdata = {8'h00, st_r.pwrMode};
                `REASON_INFO_OFFSET: st_nxt.rdata = st_r.info;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.state <= power_cycling_pkg::ST_CABLE_RUN;
            st_r.pwrMode <= `PWR_MODE_CABLE;
            st_r.info <= 16'h0000;
            st_r.secCnt <= 32'h0;
            st_r.secElapsed <= 32'h0;
            st_r.mainPrev <= 1'b1;
            st_r.extPrev <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.rvalid <= 1'b0;
            st_r.powerOn <= 1'b1;
            st_r.shutReq <= 1'b0;
            st_r.beepStart <= 1'b0;
            st_r.onBat <= 1'b0;
            st_r.asleep <= 1'b0;
            st_r.rtcOn <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign regRdata = st_r.rdata;
    assign regRvalid = st_r.rvalid;
    assign systemPowerOn = st_r.powerOn;
    assign onBattery = st_r.onBat;
    assign shutdownRequest = st_r.shutReq;
    assign sleepActive = st_r.asleep;
    assign rtcRun = st_r.rtcOn;

endmodule // power_cycling_sequencer

/* power_cycling_monitor.sv */
`timescale 1ns/10ps

module power_cycling_monitor #(
    parameter logic [31:0] RUN_TIME_SEC = 3,
    parameter logic [31:0] SEC_CYCLES = 10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // inputs watched
    input wire logic mainCablePresent,
    input wire logic extInputPresent,
    input wire logic extInputFitted,
    input wire logic buttonPress,
    input wire logic simpleSchedWake,
    input wire logic extSchedWake,
    input wire logic eventWake,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    // outputs watched
    input wire logic [15:0] regRdata,
    input wire logic regRvalid,
    input wire logic systemPowerOn,
    input wire logic onBattery,
    input wire logic shutdownRequest,
    input wire logic sleepActive,
    input wire logic rtcRun,
    input wire logic beeper
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // battery run length counter
    logic [31:0] runCnt_r;
    logic [31:0] runCnt_nxt;
    logic cableOk;
    assign cableOk = mainCablePresent || (extInputFitted && extInputPresent);
    always_comb begin
        runCnt_nxt = (onBattery && systemPowerOn && !shutdownRequest) ? runCnt_r + 32'h1 : '0;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            runCnt_r <= '0;
        end else begin
            runCnt_r <= runCnt_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_shut_start;
        $rose(shutdownRequest);
    endsequence
    sequence s_shut_hold;
        shutdownRequest [*8];
    endsequence
    a_read_answered: assert property (regRead |=> regRvalid)
        else $error("read not answered");
    a_mode_value: assert property (regRead && regAddr == 8'h00 |=>
        regRdata == ($past(onBattery) ? 16'h0002 : 16'h0001)) else $error("mode value wrong");
    a_loss_to_battery: assert property (systemPowerOn && !shutdownRequest && !onBattery
        && !cableOk && !buttonPress |=> onBattery) else $error("no switch to battery");
    a_loss_beeps: assert property ($rose(onBattery) && $past(systemPowerOn)
        && systemPowerOn |=> beeper) else $error("no beep on battery switch");
    a_run_limit: assert property (runCnt_r <= RUN_TIME_SEC * SEC_CYCLES + 2)
        else $error("battery run too long");
    a_shutdown_span: assert property (s_shut_start |-> s_shut_hold ##[1:16] !systemPowerOn)
        else $error("shutdown span wrong");
    a_shutdown_sleeps: assert property ($fell(shutdownRequest) |-> sleepActive && !systemPowerOn)
        else $error("shutdown did not cut power");
    a_rtc_running: assert property (rtcRun)
        else $error("clock stopped");
    a_button_wake: assert property (sleepActive && buttonPress |=> systemPowerOn)
        else $error("button did not wake");
    a_sched_wake: assert property (sleepActive && (simpleSchedWake || extSchedWake
        || eventWake) |=> systemPowerOn) else $error("scheduler did not wake");
    a_cable_poll: assert property (sleepActive && $rose(mainCablePresent)
        |-> ##[1:51] systemPowerOn) else $error("cable wake too late");
endmodule // power_cycling_monitor

/* host_model.sv */
`timescale 1ns/10ps

module host_model (
    // clock
    input wire logic core_clk,
    // register strobes
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [15:0] regWdata,
    // answer
    input wire logic [15:0] regRdata,
    input wire logic regRvalid
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 16'h0000;
    end
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge core_clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d = (regRvalid === 1'b1) ? regRdata : 16'hxxxx;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge core_clk);
        #1;
        regAddr = a;
        regWdata = w;
        regWrite = 1'b1;
        @(posedge core_clk);
        #1;
        regWrite = 1'b0;
        regAddr = ~a;
        regWdata = ~w;
    endtask
    // read the information word, then clear it
    task automatic rdClr(output logic [15:0] d);
        rd(8'h28, d);
        wr(8'h28, 16'h0000);
    endtask
endmodule // host_model

/* power_cycling_sequencer_tb_top.sv */
`timescale 1ns/10ps
`include "power_cycling_defs.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module power_cycling_sequencer_tb_top;
    logic core_clk, resetn, mainCablePresent, extInputPresent, extInputFitted;
    logic [8:0] ev;
    logic [3:0] restartCause;
    logic restartCauseValid, regWrite, regRead, regRvalid, systemPowerOn, onBattery;
    logic shutdownRequest, sleepActive, rtcRun, statusLed, beeper;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata, d;
    logic [31:0] seed, r;
    logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'he, 4'hf};
    int sdBit [5] = '{0, 1, 2, 3, 4};
    logic [3:0] sdCode [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    int wkBit [5] = '{0, 5, 6, 7, 0};
    logic [3:0] wkCode [5] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h1};
    int n_fail = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    power_cycling_sequencer #(.RUN_TIME_SEC(3), .SHUTDOWN_SEC(2), .SEC_CYCLES(10),
        .POLL_CYCLES(50), .BLINK_ON_CYCLES(8)) dut_u (
        .core_clk(core_clk), .resetn(resetn), .mainCablePresent(mainCablePresent),
        .extInputPresent(extInputPresent), .extInputFitted(extInputFitted),
        .buttonPress(ev[0]), .lowBattery(ev[1]), .simpleSchedOff(ev[2]),
        .extSchedOff(ev[3]), .eventOff(ev[4]), .simpleSchedWake(ev[5]),
        .extSchedWake(ev[6]), .eventWake(ev[7]), .hostRebooted(ev[8]),
        .restartCause(restartCause), .restartCauseValid(restartCauseValid),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid), .systemPowerOn(systemPowerOn),
        .onBattery(onBattery), .shutdownRequest(shutdownRequest),
        .sleepActive(sleepActive), .rtcRun(rtcRun), .statusLed(statusLed), .beeper(beeper));
    host_model host_u (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
    ////////////////////////////////////////////////////////////////////////////////
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] infoExp(logic [3:0] wk, logic [3:0] sd);
        return {8'h00, wk, sd};
    endfunction
    function automatic logic curSig(int k);
        return (k == 0) ? shutdownRequest : systemPowerOn;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(int b);
        ev[b] = 1'b1;
        tick(1);
        ev = '0;
    endtask
    task automatic waitSig(int k, logic v, int lim, string nm);
        int n;
        n = 0;
        while (curSig(k) !== v && n < lim) begin
            tick(1);
            n++;
        end
        `CHK(nm, v, curSig(k))
    endtask
    task automatic rdExp(logic [7:0] a, logic [15:0] e, string nm);
        host_u.rd(a, d);
        `CHK(nm, e, d)
    endtask
    task automatic stop_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        seed = 32'd51365;
        mainCablePresent = 1'b1;
        extInputPresent = 1'b0;
        extInputFitted = 1'b0;
        ev = '0;
        restartCause = 4'h0;
        restartCauseValid = 1'b0;
        tick(4);
        resetn = 1'b1;
        rdExp(8'h00, 16'h0001, "mode");
        r = rnd();
        host_u.wr(8'h00, r[15:0]);
        rdExp(8'h00, 16'h0001, "mode ro");
        r = rnd();
        if (r[7:0] == 8'h00 || r[7:0] == 8'h28) r[7:0] = 8'h55;
        rdExp(r[7:0], 16'h0000, "unmapped");
        $display("test registers done");
        foreach (codes[i]) begin
            restartCause = codes[i];
            restartCauseValid = 1'b1;
            tick(1);
            restartCauseValid = 1'b0;
            rdExp(8'h28, {4'h0, codes[i], 8'h00}, "restart");
            r = rnd();
            host_u.wr(8'h28, r[15:0] | 16'h0100);
            rdExp(8'h28, {4'h0, codes[i], 8'h00}, "no clear");
            host_u.wr(8'h28, 16'h0000);
            rdExp(8'h28, 16'h0000, "cleared");
        end
        $display("test restart done");
        mainCablePresent = 1'b0;
        tick(1);
        `CHK("onBattery", 1'b1, onBattery)
        tick(1);
        `CHK("beeper", 1'b1, beeper)
        rdExp(8'h00, 16'h0002, "mode bat");
        waitSig(0, 1'b1, 40, "timed shutdown");
        rdExp(8'h28, infoExp(4'h0, 4'h3), "sd timed");
        `CHK("led solid", 1'b1, statusLed)
        waitSig(1, 1'b0, 30, "sleep");
        `CHK("rtc", 1'b1, rtcRun)
        pulse(0);
        waitSig(1, 1'b1, 2, "button wake");
        `CHK("wake bat", 1'b1, onBattery)
        host_u.rdClr(d);
        `CHK("wk button", infoExp(4'h1, 4'h3), d)
        $display("test cable loss done");
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            tick(r[1:0] + 1);
            ev[sdBit[i]] = 1'b1;
            tick(1);
            if (sdBit[i] != 1) ev = '0;
            waitSig(0, 1'b1, 4, "sd start");
            ev = '0;
            rdExp(8'h28, infoExp(4'h0, sdCode[i]), "sd code");
            waitSig(1, 1'b0, 30, "sd sleep");
            pulse(wkBit[i]);
            waitSig(1, 1'b1, 2, "wake");
            host_u.rdClr(d);
            `CHK("wk code", infoExp(wkCode[i], sdCode[i]), d)
        end
        pulse(8);
        host_u.rdClr(d);
        `CHK("wk reboot", infoExp(4'h3, 4'h0), d)
        $display("test reasons done");
        waitSig(1, 1'b0, 60, "timed sleep");
        mainCablePresent = 1'b1;
        waitSig(1, 1'b1, 55, "cable wake");
        rdExp(8'h00, 16'h0001, "mode cable");
        host_u.rdClr(d);
        `CHK("wk cable", infoExp(4'h2, 4'h3), d)
        extInputFitted = 1'b1;
        pulse(0);
        waitSig(1, 1'b0, 30, "cable sleep");
        tick(3);
        `CHK("power cut", 1'b0, systemPowerOn)
        `CHK("led off", 1'b0, statusLed)
        extInputPresent = 1'b1;
        waitSig(1, 1'b1, 55, "ext wake");
        host_u.rdClr(d);
        `CHK("wk ext", infoExp(4'h4, 4'h1), d)
        mainCablePresent = 1'b0;
        tick(2);
        `CHK("ext holds", 1'b0, onBattery)
        extInputPresent = 1'b0;
        tick(1);
        `CHK("ext loss", 1'b1, onBattery)
        $display("test external input done");
        stop_test();
    end
endmodule // power_cycling_sequencer_tb_top

bind power_cycling_sequencer power_cycling_monitor #(.RUN_TIME_SEC(RUN_TIME_SEC),
    .SEC_CYCLES(SEC_CYCLES)) mon_u (.core_clk(core_clk), .resetn(resetn),
    .mainCablePresent(mainCablePresent), .extInputPresent(extInputPresent),
    .extInputFitted(extInputFitted), .buttonPress(buttonPress),
    .simpleSchedWake(simpleSchedWake), .extSchedWake(extSchedWake), .eventWake(eventWake),
    .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata), .regRvalid(regRvalid),
    .systemPowerOn(systemPowerOn), .onBattery(onBattery), .shutdownRequest(shutdownRequest),
    .sleepActive(sleepActive), .rtcRun(rtcRun), .beeper(beeper));
